// ---- bench/spc_peer.sv ----
// Serial peer: drives the receive line with whole asynchronous frames.
// Assumes the system clock; its transfer clock runs only while a slave transfer is asked for.
`timescale 1ns/1ps
module spc_peer (
  input  wire clk,
  output reg  rxd,
  output reg  xck_in
);
  // The line idles high and the transfer clock is parked low.
  initial begin
    rxd = 1'b1;
    xck_in = 1'b0;
  end
  // Start, eight bits LSB first, a stop of the given level, one idle bit.
  task send(input [7:0] d, input stp, input integer bitc);
    reg [10:0] f;
    integer    i;
    begin
      f = {1'b1, stp, d, 1'b0};
      for (i = 0; i < 11; i = i + 1) begin
        rxd <= f[i];
        repeat (bitc) @(posedge clk);
      end
    end
  endtask
  // Slave transfer clock: n toggles, h system clocks each, parked low after an even count.
  task transfer_clock_pin(input integer n, input integer h);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        xck_in <= ~xck_in;
        repeat (h) @(posedge clk);
      end
    end
  endtask
endmodule

// ---- bench/spc_top_sva.sv ----
// Checker of the serial port top: read port, status bits and pin enables.
// Assumes it is bound into spc_top and sees only that module's ports.
`timescale 1ns/1ps
module spc_top_sva (
  input wire clk, input wire rst, input wire [2:0] reg_addr, input wire [7:0] reg_wdata,
  input wire reg_we, input wire reg_re, input wire [7:0] reg_rdata, input wire txd,
  input wire txd_oe, input wire xck_out, input wire xck_oe, input wire irq_tx_complete,
  input wire irq_rx_complete
);
  // One clock domain; every check rests while reset is high.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rd_idle; !reg_re |=> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle read");
  property p_unmap; reg_re && reg_addr == 3'h7 |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_rx_flag; reg_re && reg_addr == 3'h1 |=> reg_rdata[7] == $past(irq_rx_complete);
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("rx flag");
  property p_txc; reg_re && reg_addr == 3'h1 |=> reg_rdata[6] == $past(irq_tx_complete);
  endproperty
  a_txc: assert property (p_txc) else $error("tx done flag");
  property p_xck_q; !xck_oe |=> !xck_out; endproperty
  a_xck_q: assert property (p_xck_q) else $error("clock out");
  property p_async; reg_we && reg_addr == 3'h3 && !reg_wdata[0] |=> !xck_oe; endproperty
  a_async: assert property (p_async) else $error("async clock pin");
  property p_pwr; reg_we && reg_addr == 3'h6 && reg_wdata[0]
    |=> !txd_oe && !xck_oe && !irq_rx_complete; endproperty
  a_pwr: assert property (p_pwr) else $error("power off");
  property p_start; $fell(txd) |=> !txd; endproperty
  a_start: assert property (p_start) else $error("short bit");
endmodule

bind spc_top spc_top_sva chk_u (.*);

// ---- bench/spc_top_tb.sv ----
// Bench of the serial port top: registers, clock modes and receive path.
// Assumes spc_top, its bound checker and the serial peer model.
`timescale 1ns/1ps
module spc_top_tb;
  reg         clk, rst, reg_we, reg_re;
  reg  [2:0]  reg_addr;
  reg  [7:0]  reg_wdata, got;
  reg  [18:0] rows [0:3];
  wire [7:0]  reg_rdata;
  wire        rxd, txd, txd_oe, xck_in, xck_out, xck_oe;
  wire        irq_tx_complete, irq_tx_empty, irq_rx_complete;
  integer     n_errors, cmp_count, m, i, len;
  `define CHK(nm, e, a) begin cmp_count = cmp_count + 1; if ((a) !== (e)) begin \
    n_errors = n_errors + 1; $display("ERROR %s exp %0h got %0h", nm, e, a); end end
  spc_top  dut_u (.*);
  spc_peer peer_u (.clk(clk), .rxd(rxd), .xck_in(xck_in));
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // One access: write when w is high, else read into got.
  task acc(input w, input [2:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= w;
      reg_re <= !w;
      @(posedge clk);
      reg_we <= 1'b0;
      reg_re <= 1'b0;
      #1 got = reg_rdata;
      @(posedge clk);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task give_verdict;
    begin
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // The tests need about 3500 cycles; this limit is far beyond.
  initial begin
    #60000;
    n_errors = n_errors + 1;
    give_verdict;
  end
  // Reset, register rows, four clock modes, receive path, power-off.
  initial begin
    n_errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    rows[0] = {3'h2, 8'h03, 8'h03};
    rows[1] = {3'h3, 8'h00, 8'h00};
    rows[2] = {3'h4, 8'h03, 8'h03};
    rows[3] = {3'h7, 8'hFF, 8'h00};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(1'b0, 3'h1, 8'h00);
    `CHK("reset status", 8'h20, got);
    for (m = 0; m < 4; m = m + 1) begin
      acc(1'b1, rows[m][18:16], rows[m][15:8]);
      acc(1'b0, rows[m][18:16], 8'h00);
      `CHK("register", rows[m][7:0], got);
    end
    `CHK("tx empty", 1'b1, irq_tx_empty);
    for (m = 0; m < 4; m = m + 1) begin
      acc(1'b1, 3'h3, (m > 1) ? 8'h05 : 8'h00);
      acc(1'b1, 3'h1, m[0] ? 8'h42 : 8'h40);
      acc(1'b1, 3'h0, 8'hA5);
      `CHK("clock oe", (m > 1) ? 1'b1 : 1'b0, xck_oe);
      for (i = 0; i < 200 && txd !== 1'b0; i = i + 1) @(posedge clk);
      for (len = 0; len < 200 && txd === 1'b0; len = len + 1) @(posedge clk);
      `CHK("start cycles", ((m > 1) ? 2 : (m == 1) ? 8 : 16) * 4, len);
      for (i = 0; i < 900 && irq_tx_complete !== 1'b1; i = i + 1) @(posedge clk);
      `CHK("tx done", 1'b1, irq_tx_complete);
    end
    // Slave mode, data change on falling edges: the start bit lasts one peer clock period.
    acc(1'b1, 3'h3, 8'h03);
    acc(1'b1, 3'h0, 8'hA5);
    fork
      peer_u.transfer_clock_pin(24, 4);
      begin
        for (i = 0; i < 200 && txd !== 1'b0; i = i + 1) @(posedge clk);
        for (len = 0; len < 200 && txd === 1'b0; len = len + 1) @(posedge clk);
      end
    join
    `CHK("slave bit", 8, len);
    `CHK("slave done", 1'b1, irq_tx_complete);
    acc(1'b1, 3'h3, 8'h00);
    acc(1'b1, 3'h1, 8'h40);
    for (m = 0; m < 3; m = m + 1) peer_u.send(8'h11 * (m[7:0] + 8'h01), m != 1, 64);
    repeat (40) @(posedge clk);
    `CHK("rx irq", 1'b1, irq_rx_complete);
    for (m = 0; m < 3; m = m + 1) begin
      acc(1'b0, 3'h1, 8'h00);
      `CHK("rx status", (m == 1) ? 8'hB0 : 8'hA0, got);
      acc(1'b0, 3'h0, 8'h00);
      `CHK("rx data", 8'h11 * (m[7:0] + 8'h01), got);
    end
    acc(1'b0, 3'h1, 8'h00);
    // An empty FIFO pops nothing; the stale head still shows the second word's frame error.
    `CHK("rx empty", 8'h30, got);
    acc(1'b1, 3'h6, 8'h01);
    `CHK("tx pin off", 1'b0, txd_oe);
    `CHK("tx empty off", 1'b0, irq_tx_empty);
    give_verdict;
  end
endmodule

// ---- design/spc_baud_gen.v ----
// Baud rate generator: 12-bit divisor registers and a reloadable down-counter.
// Assumes one system clock; the strobes come from the register port of the top.
`timescale 1ns/1ps
`include "spc_defs.vh"

module spc_baud_gen (
  clk,
  rst,
  enable,
  wdata,
  low_we,
  high_we,
  divisor,
  tick
);
  input  wire        clk;
  input  wire        rst;
  input  wire        enable;
  input  wire [7:0]  wdata;
  input  wire        low_we;
  input  wire        high_we;
  output wire [11:0] divisor;
  output wire        tick;

  reg [7:0]  div_low_ff;
  reg [3:0]  div_high_ff;
  reg [11:0] cnt_ff;
  reg        tick_ff;

  assign divisor = {div_high_ff, div_low_ff};
  assign tick    = tick_ff;

  // ----------------------------------------------------------------------------
  // Divisor registers and counter
  // ----------------------------------------------------------------------------
  // The high part is only stored; it reaches the counter at the next reload.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_low_ff  <= `SPC_RST_DIV_LOW;
      div_high_ff <= `SPC_RST_DIV_HIGH;
      cnt_ff      <= 12'h000;
      tick_ff     <= 1'b0;
    end else begin
      if (high_we) begin
        div_high_ff <= wdata[3:0];
      end
      if (low_we) begin
        div_low_ff <= wdata;
        cnt_ff     <= {div_high_ff, wdata};
        tick_ff    <= 1'b0;
      end else if (!enable) begin
        cnt_ff  <= {div_high_ff, div_low_ff};
        tick_ff <= 1'b0;
      end else if (cnt_ff == 12'h000) begin
        cnt_ff  <= {div_high_ff, div_low_ff};
        tick_ff <= 1'b1;
      end else begin
        cnt_ff  <= cnt_ff - 12'h001;
        tick_ff <= 1'b0;
      end
    end
  end

endmodule

// ---- design/spc_defs.vh ----
// Constants for the serial port clock generator and buffers: offsets, fields, resets, counts.
// Assumes inclusion by bare name from every design file of this block.
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SPC_OFF_DATA      3'h0
`define SPC_OFF_STAT_A    3'h1
`define SPC_OFF_CTRL_B    3'h2
`define SPC_OFF_CTRL_C    3'h3
`define SPC_OFF_DIV_LOW   3'h4
`define SPC_OFF_DIV_HIGH  3'h5
`define SPC_OFF_POWER     3'h6

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SPC_A_RX_DONE     7
`define SPC_A_TX_DONE     6
`define SPC_A_TX_EMPTY    5
`define SPC_A_FRAME_ERR   4
`define SPC_A_OVERRUN     3
`define SPC_A_PARITY_ERR  2
`define SPC_A_DOUBLE      1
`define SPC_A_NINTH       0
`define SPC_B_RX_EN       0
`define SPC_B_TX_EN       1
`define SPC_B_TX_NINTH    2
`define SPC_B_NINE_BITS   3
`define SPC_B_PAR_EN      4
`define SPC_B_PAR_ODD     5
`define SPC_C_SYNC        0
`define SPC_C_POLARITY    1
`define SPC_C_CLK_DIR     2
`define SPC_P_POWER_OFF   0

// Fields of a receive FIFO word.
`define SPC_W_NINTH       8
`define SPC_W_PARITY_ERR  9
`define SPC_W_OVERRUN     10
`define SPC_W_FRAME_ERR   11

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SPC_RST_CTRL_B    6'h00
`define SPC_RST_CTRL_C    3'h0
`define SPC_RST_DOUBLE    1'b0
`define SPC_RST_POWER_OFF 1'b0
`define SPC_RST_DIV_LOW   8'h00
`define SPC_RST_DIV_HIGH  4'h0

// ----------------------------------------------------------------------------
// Timing counts, in baud generator ticks
// ----------------------------------------------------------------------------
`define SPC_LAST_NORMAL   4'hF
`define SPC_LAST_DOUBLE   4'h7
`define SPC_MID_NORMAL    4'h8
`define SPC_MID_DOUBLE    4'h4

`endif

// ---- design/spc_rx_fifo.v ----
// Two-entry circular receive FIFO holding data, ninth bit and error flags per word.
// Assumes push and pop are single-cycle strobes from the top; clear empties it.
`timescale 1ns/1ps
`include "spc_defs.vh"

module spc_rx_fifo (
  clk,
  rst,
  clear,
  push,
  push_data,
  pop,
  head,
  empty,
  full
);
  input  wire        clk;
  input  wire        rst;
  input  wire        clear;
  input  wire        push;
  input  wire [11:0] push_data;
  input  wire        pop;
  output wire [11:0] head;
  output wire        empty;
  output wire        full;

  reg [11:0] mem_ff [0:1];
  reg        wr_ptr_ff;
  reg        rd_ptr_ff;
  reg [1:0]  count_ff;

  wire do_push = push && (count_ff != 2'h2);
  wire do_pop  = pop && (count_ff != 2'h0);

  assign head  = mem_ff[rd_ptr_ff];
  assign empty = (count_ff == 2'h0);
  assign full  = (count_ff == 2'h2);

  // ----------------------------------------------------------------------------
  // Pointers and storage
  // ----------------------------------------------------------------------------
  // Each pop removes exactly one word unless the FIFO is empty, so every word is delivered once.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_ff[0] <= 12'h000;
      mem_ff[1] <= 12'h000;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else if (clear) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'h0;
    end else begin
      if (do_push) begin
        mem_ff[wr_ptr_ff] <= push_data;
        wr_ptr_ff         <= ~wr_ptr_ff;
      end
      if (do_pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (do_push && !do_pop) begin
        count_ff <= count_ff + 2'h1;
      end else if (do_pop && !do_push) begin
        count_ff <= count_ff - 2'h1;
      end
    end
  end

endmodule

// ---- design/spc_top.v ----
// Serial port with clock generator, transmit write buffer and three-level receive path.
// Assumes a register master on the plain port and a serial peer on rxd, txd and the clock pin.
//
// Overview of operation
// - Four clock modes: normal async, double-speed async, sync master, sync slave.
// - Sync select picks sync operation; clock direction then picks master or slave.
// - The transfer clock pin is used only in synchronous mode.
// - Slave mode synchronises the incoming clock; master mode drives the clock out.
// - Baud counter runs on system clock, reloads at zero and on low write.
// - One baud tick per counter zero, rate is clock over divisor plus one.
// - Transmitter divides baud ticks by 2, 8 or 16 depending on mode.
// - Receiver uses undivided ticks with a 16 or 8 state recovery counter when async; sync samples on the clock edge.
// - Bit rate is clock over factor 16, 8 or 2 times divisor plus one.
// - Divisor is twelve bits, from the high and low register parts.
// - Double speed doubles async rate and does nothing in sync mode.
// - One write buffer ahead of the shifter gives back-to-back frames.
// - Receive data is a two-entry FIFO; each read removes one word.
// - Error flags and ninth bit travel with each word; read status first.
// - With the FIFO full a finished word waits in a hold register until next start.
// - Receiver reports framing, overrun and parity errors.
// - Three requests: transmit complete, transmit buffer empty, receive complete.
// - The port works only while power-off is zero.
// - Slave clock passes a synchroniser and edge detector, two cycles of delay.
// - Polarity zero changes data on rising edge, samples on falling; one swaps.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "spc_defs.vh"

module spc_top (
  clk,
  rst,
  reg_addr,
  reg_wdata,
  reg_we,
  reg_re,
  reg_rdata,
  rxd,
  txd,
  txd_oe,
  xck_in,
  xck_out,
  xck_oe,
  irq_tx_complete,
  irq_tx_empty,
  irq_rx_complete
);
  input  wire       clk;
  input  wire       rst;
  input  wire [2:0] reg_addr;
  input  wire [7:0] reg_wdata;
  input  wire       reg_we;
  input  wire       reg_re;
  output wire [7:0] reg_rdata;
  input  wire       rxd;
  output wire       txd;
  output wire       txd_oe;
  input  wire       xck_in;
  output wire       xck_out;
  output wire       xck_oe;
  output wire       irq_tx_complete;
  output wire       irq_tx_empty;
  output wire       irq_rx_complete;

  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_DATA  = 2'h2;
  localparam ST_STOP  = 2'h3;

  // Parity over data and ninth bit; odd parity inverts the result.
  function par_of;
    input [7:0] data;
    input       ninth;
    input       nine;
    input       odd;
    begin
      par_of = (^data) ^ (nine & ninth) ^ odd;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------------
  reg [5:0]  ctrl_b_ff;
  reg [2:0]  ctrl_c_ff;
  reg        double_ff;
  reg        power_off_ff;
  reg [7:0]  rdata_ff;
  reg        tx_done_ff;
  reg [7:0]  tx_buf_ff;
  reg        tx_buf_ninth_ff;
  reg        tx_buf_full_ff;

  wire [11:0] divisor;
  wire        baud_tick;
  wire [11:0] fifo_head;
  wire        fifo_empty;
  wire        fifo_full;

  wire active    = !power_off_ff;
  wire rx_en     = ctrl_b_ff[`SPC_B_RX_EN] && active;
  wire tx_en     = ctrl_b_ff[`SPC_B_TX_EN] && active;
  wire nine      = ctrl_b_ff[`SPC_B_NINE_BITS];
  wire par_en    = ctrl_b_ff[`SPC_B_PAR_EN];
  wire par_odd   = ctrl_b_ff[`SPC_B_PAR_ODD];
  wire sync_mode = ctrl_c_ff[`SPC_C_SYNC];
  wire polarity  = ctrl_c_ff[`SPC_C_POLARITY];
  wire master    = sync_mode && ctrl_c_ff[`SPC_C_CLK_DIR];
  wire slave     = sync_mode && !ctrl_c_ff[`SPC_C_CLK_DIR];
  wire dbl       = double_ff && !sync_mode;

  wire wr_data = reg_we && (reg_addr == `SPC_OFF_DATA);
  wire wr_stat = reg_we && (reg_addr == `SPC_OFF_STAT_A);
  wire rd_data = reg_re && (reg_addr == `SPC_OFF_DATA);

  // ----------------------------------------------------------------------------
  // Clock generation
  // ----------------------------------------------------------------------------
  spc_baud_gen u_baud (
    .clk     (clk),
    .rst     (rst),
    .enable  (active),
    .wdata   (reg_wdata),
    .low_we  (reg_we && (reg_addr == `SPC_OFF_DIV_LOW)),
    .high_we (reg_we && (reg_addr == `SPC_OFF_DIV_HIGH)),
    .divisor (divisor),
    .tick    (baud_tick)
  );

  reg       xck_meta_ff;
  reg       xck_sync_ff;
  reg       xck_prev_ff;
  reg       xck_gen_ff;
  reg [3:0] pre_cnt_ff;

  // Slave clock: two-stage synchroniser, then a third stage for edge detection.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      xck_meta_ff <= 1'b0;
      xck_sync_ff <= 1'b0;
      xck_prev_ff <= 1'b0;
    end else begin
      xck_meta_ff <= xck_in;
      xck_sync_ff <= xck_meta_ff;
      xck_prev_ff <= xck_sync_ff;
    end
  end

  // Master clock toggles on each baud tick, giving a factor of two.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      xck_gen_ff <= 1'b0;
    end else if (!master || !active) begin
      xck_gen_ff <= 1'b0;
    end else if (baud_tick) begin
      xck_gen_ff <= ~xck_gen_ff;
    end
  end

  // Rising and falling transfer clock edges for either sync mode.
  wire rise_m  = master && baud_tick && !xck_gen_ff;
  wire fall_m  = master && baud_tick && xck_gen_ff;
  wire rise_s  = slave && xck_sync_ff && !xck_prev_ff;
  wire fall_s  = slave && !xck_sync_ff && xck_prev_ff;
  wire rise    = (rise_m || rise_s) && active;
  wire fall    = (fall_m || fall_s) && active;
  wire chg_edge = polarity ? fall : rise;
  wire smp_edge = polarity ? rise : fall;

  wire [3:0] last = dbl ? `SPC_LAST_DOUBLE : `SPC_LAST_NORMAL;
  wire [3:0] mid  = dbl ? `SPC_MID_DOUBLE : `SPC_MID_NORMAL;

  // Transmit prescaler for the asynchronous modes.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_cnt_ff <= 4'h0;
    end else if (sync_mode || !active) begin
      pre_cnt_ff <= 4'h0;
    end else if (baud_tick) begin
      pre_cnt_ff <= (pre_cnt_ff >= last) ? 4'h0 : pre_cnt_ff + 4'h1;
    end
  end

  // Transmit bit clock: divided ticks when async, change edge when sync.
  wire tx_tick = sync_mode ? chg_edge
                           : (baud_tick && (pre_cnt_ff == last));

  assign xck_out = xck_gen_ff;
  assign xck_oe  = master && active;

  // ----------------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------------
  reg [11:0] tx_sh_ff;
  reg [3:0]  tx_left_ff;
  reg        tx_busy_ff;
  reg        txd_ff;

  // Frame of start, eight data, optional ninth, optional parity and a stop.
  wire [11:0] frame = {1'b1,
                       (nine && par_en) ? par_of(tx_buf_ff, tx_buf_ninth_ff, 1'b1, par_odd)
                                        : 1'b1,
                       nine ? tx_buf_ninth_ff
                            : (par_en ? par_of(tx_buf_ff, 1'b0, 1'b0, par_odd) : 1'b1),
                       tx_buf_ff, 1'b0};
  wire [3:0]  frame_bits = 4'hA + {3'h0, nine} + {3'h0, par_en};
  wire        tx_load = tx_en && tx_tick && !(tx_busy_ff && (tx_left_ff != 4'h0))
                        && tx_buf_full_ff;

  // Shifter: when the stop bit ends, a waiting buffer loads with no idle gap.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_sh_ff   <= 12'hFFF;
      tx_left_ff <= 4'h0;
      tx_busy_ff <= 1'b0;
      txd_ff     <= 1'b1;
    end else if (!tx_en) begin
      tx_busy_ff <= 1'b0;
      tx_left_ff <= 4'h0;
      txd_ff     <= 1'b1;
    end else if (tx_tick) begin
      if (tx_busy_ff && (tx_left_ff != 4'h0)) begin
        txd_ff     <= tx_sh_ff[0];
        tx_sh_ff   <= {1'b1, tx_sh_ff[11:1]};
        tx_left_ff <= tx_left_ff - 4'h1;
      end else if (tx_load) begin
        txd_ff     <= frame[0];
        tx_sh_ff   <= {1'b1, frame[11:1]};
        tx_left_ff <= frame_bits - 4'h1;
        tx_busy_ff <= 1'b1;
      end else begin
        tx_busy_ff <= 1'b0;
        txd_ff     <= 1'b1;
      end
    end
  end

  wire tx_finish = tx_en && tx_tick && tx_busy_ff && (tx_left_ff == 4'h0)
                   && !tx_buf_full_ff;

  // Write buffer; a write into a full buffer is ignored unless it drains now.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_buf_ff       <= 8'h00;
      tx_buf_ninth_ff <= 1'b0;
      tx_buf_full_ff  <= 1'b0;
    end else if (!active) begin
      tx_buf_full_ff <= 1'b0;
    end else if (wr_data && (!tx_buf_full_ff || tx_load)) begin
      tx_buf_ff       <= reg_wdata;
      tx_buf_ninth_ff <= ctrl_b_ff[`SPC_B_TX_NINTH];
      tx_buf_full_ff  <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full_ff <= 1'b0;
    end
  end

  // Transmit complete is sticky; a set in the clearing cycle wins.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_done_ff <= 1'b0;
    end else if (tx_finish) begin
      tx_done_ff <= 1'b1;
    end else if ((wr_stat && reg_wdata[`SPC_A_TX_DONE]) || wr_data || !active) begin
      tx_done_ff <= 1'b0;
    end
  end

  assign txd    = txd_ff;
  assign txd_oe = tx_en;

  // ----------------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------------
  reg [1:0]  rx_st_ff;
  reg [3:0]  rx_smp_ff;
  reg [3:0]  rx_cnt_ff;
  reg [9:0]  rx_sh_ff;
  reg        hold_ff;
  reg [11:0] hold_word_ff;
  reg        ovr_pend_ff;

  // Recovery counter wraps at 16 or 8 ticks; in sync mode each sample edge is a bit.
  wire bit_smp = sync_mode ? smp_edge
                           : (baud_tick && (rx_smp_ff == mid));
  wire start_det = rx_en && (rx_st_ff == ST_IDLE) && !rxd
                   && (sync_mode ? smp_edge : baud_tick);
  wire [3:0] rx_bits = 4'h8 + {3'h0, nine} + {3'h0, par_en};
  wire [9:0] aligned = rx_sh_ff >> (4'hA - rx_bits);
  wire       rx_ninth = nine ? aligned[8] : 1'b0;
  wire       rx_pbit  = nine ? aligned[9] : aligned[8];
  wire       par_bad  = par_en && (par_of(aligned[7:0], rx_ninth, nine, par_odd) != rx_pbit);
  wire       word_done = rx_en && (rx_st_ff == ST_STOP) && bit_smp;
  wire [11:0] new_word = {!rxd, ovr_pend_ff, par_bad, rx_ninth, aligned[7:0]};

  // Frame state machine: start check, data and parity bits, first stop bit.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_ff  <= ST_IDLE;
      rx_smp_ff <= 4'h0;
      rx_cnt_ff <= 4'h0;
      rx_sh_ff  <= 10'h000;
    end else if (!rx_en) begin
      rx_st_ff <= ST_IDLE;
    end else begin
      if (baud_tick && !sync_mode) begin
        rx_smp_ff <= (rx_smp_ff >= last) ? 4'h0 : rx_smp_ff + 4'h1;
      end
      case (rx_st_ff)
        ST_IDLE: begin
          if (start_det) begin
            rx_st_ff  <= sync_mode ? ST_DATA : ST_START;
            rx_smp_ff <= 4'h1;
            rx_cnt_ff <= 4'h0;
          end
        end
        ST_START: begin
          if (bit_smp) begin
            rx_st_ff <= rxd ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (bit_smp) begin
            rx_sh_ff  <= {rxd, rx_sh_ff[9:1]};
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            if (rx_cnt_ff == rx_bits - 4'h1) begin
              rx_st_ff <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (bit_smp) begin
            rx_st_ff <= ST_IDLE;
          end
        end
        default: begin
          rx_st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  wire push_hold = hold_ff && !fifo_full;
  wire push_new  = word_done && !fifo_full && !hold_ff;
  wire drop_hold = start_det && hold_ff && fifo_full;

  // Third level: a finished word waits here while both FIFO entries are taken.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_ff      <= 1'b0;
      hold_word_ff <= 12'h000;
      ovr_pend_ff  <= 1'b0;
    end else if (!rx_en) begin
      hold_ff     <= 1'b0;
      ovr_pend_ff <= 1'b0;
    end else begin
      if (word_done && !push_new) begin
        hold_ff      <= 1'b1;
        hold_word_ff <= new_word;
      end else if (push_hold || drop_hold) begin
        hold_ff <= 1'b0;
      end
      if (drop_hold) begin
        ovr_pend_ff <= 1'b1;
      end else if (word_done) begin
        ovr_pend_ff <= 1'b0;
      end
    end
  end

  spc_rx_fifo u_fifo (
    .clk       (clk),
    .rst       (rst),
    .clear     (!rx_en),
    .push      (push_hold || push_new),
    .push_data (push_hold ? hold_word_ff : new_word),
    .pop       (rd_data),
    .head      (fifo_head),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );

  // ----------------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------------
  // Configuration writes; power-off stays writable so the port can be woken.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_b_ff    <= `SPC_RST_CTRL_B;
      ctrl_c_ff    <= `SPC_RST_CTRL_C;
      double_ff    <= `SPC_RST_DOUBLE;
      power_off_ff <= `SPC_RST_POWER_OFF;
    end else if (reg_we) begin
      case (reg_addr)
        `SPC_OFF_STAT_A: double_ff    <= reg_wdata[`SPC_A_DOUBLE];
        `SPC_OFF_CTRL_B: ctrl_b_ff    <= reg_wdata[5:0];
        `SPC_OFF_CTRL_C: ctrl_c_ff    <= reg_wdata[2:0];
        `SPC_OFF_POWER:  power_off_ff <= reg_wdata[`SPC_P_POWER_OFF];
        default: begin
        end
      endcase
    end
  end

  // Read data stand in the cycle after the strobe; unmapped offsets read zero.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_re) begin
      case (reg_addr)
        `SPC_OFF_DATA:     rdata_ff <= fifo_head[7:0];
        `SPC_OFF_STAT_A:   rdata_ff <= {!fifo_empty, tx_done_ff, !tx_buf_full_ff,
                                        fifo_head[`SPC_W_FRAME_ERR],
                                        fifo_head[`SPC_W_OVERRUN],
                                        fifo_head[`SPC_W_PARITY_ERR],
                                        double_ff, fifo_head[`SPC_W_NINTH]};
        `SPC_OFF_CTRL_B:   rdata_ff <= {2'h0, ctrl_b_ff};
        `SPC_OFF_CTRL_C:   rdata_ff <= {5'h00, ctrl_c_ff};
        `SPC_OFF_DIV_LOW:  rdata_ff <= divisor[7:0];
        `SPC_OFF_DIV_HIGH: rdata_ff <= {4'h0, divisor[11:8]};
        `SPC_OFF_POWER:    rdata_ff <= {7'h00, power_off_ff};
        default:           rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata       = rdata_ff;
  assign irq_tx_complete = tx_done_ff;
  assign irq_tx_empty    = tx_en && !tx_buf_full_ff;
  assign irq_rx_complete = rx_en && !fifo_empty;

endmodule
